// ===== common/pced_defines.svh
// Constants for the pin change edge detector: offsets, field layout, reset values.
`ifndef PCED_DEFINES_SVH
`define PCED_DEFINES_SVH
`define PCED_NPINS 6
`define PCED_RISE_OFS 12'h000
`define PCED_FALL_OFS 12'h004
`define PCED_FLAG_OFS 12'h008
`define PCED_CTRL_OFS 12'h00c
`define PCED_CTRL_MEN_BIT 0
`define PCED_CTRL_SUM_BIT 1
`define PCED_PIN_MASK 8'h3f
`define PCED_REG_RESET 8'h00
`endif

// ===== common/pced_pkg.sv
// Types for the pin change edge detector.
package pced_pkg;
   typedef enum logic [1:0] {PCED_IDLE, PCED_WRITE} pced_phase_t;
   typedef logic [5:0] pced_pins_t;
endpackage

// ===== rtl/pced_edge_cell.sv
// One pin's edge detector and sticky change flag.
`timescale 1ns/100ps
`include "pced_defines.svh"
module pced_edge_cell
   import pced_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Pin and arming.
   input wire logic pin_now,
   input wire logic pin_prev,
   input wire logic rise_en,
   input wire logic fall_en,
   // Software access to the flag.
   input wire logic sw_write,
   input wire logic sw_value,
   // Flag state.
   output logic flag,
   output logic hit
);
   logic flag_r;

   // The comparison with the previous sample catches both directions independently.
   assign hit = (rise_en & pin_now & ~pin_prev) | (fall_en & ~pin_now & pin_prev);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flag_r <= 1'b0;
      else if (hit)
         flag_r <= 1'b1;
      else if (sw_write)
         flag_r <= sw_value;
   end

   assign flag = flag_r;

   flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hit |=> flag)
      else $error("flag not set after enabled edge");
   set_beats_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (hit && sw_write && !sw_value) |=> flag)
      else $error("clear won over edge");
   flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (flag && !sw_write) |=> flag)
      else $error("flag dropped without write");
   no_arm_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!rise_en && !fall_en && !flag && !(sw_write && sw_value)) |=> !flag)
      else $error("flag set with edges disarmed");
endmodule

// ===== rtl/pced_top.sv
// AHB-Lite slave with six-pin change detection, summary flag and wake request.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "pced_defines.svh"
module pced_top
   import pced_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Port pins, already synchronous to hclk.
   input wire logic [5:0] port_pin,
   // System side.
   output logic pin_change_irq,
   output logic pin_change_summary_flag,
   output logic wake_req
);
   logic [5:0] rise_edge_enable_r;
   logic [5:0] fall_edge_enable_r;
   logic pin_change_master_enable_r;
   logic [5:0] pin_prev_r;
   logic [5:0] flags;
   logic [5:0] hits;
   logic [11:0] addr_r;
   logic wr_pend_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_nxt;
   pced_phase_t phase_r;
   logic acc;
   logic flag_wr;

   assign acc = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase is latched; the write lands in the data phase when hwdata is valid.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_r <= 12'h000;
         wr_pend_r <= 1'b0;
         phase_r <= PCED_IDLE;
      end
      else
      begin
         addr_r <= haddr;
         wr_pend_r <= acc & hwrite;
         phase_r <= (acc & hwrite) ? PCED_WRITE : PCED_IDLE;
      end
   end

   // Enable and master registers; bits above 5 are not stored.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rise_edge_enable_r <= 6'h00;
         fall_edge_enable_r <= 6'h00;
         pin_change_master_enable_r <= 1'b0;
      end
      else if (wr_pend_r)
      begin
         case (addr_r)
            `PCED_RISE_OFS: rise_edge_enable_r <= hwdata[5:0];
            `PCED_FALL_OFS: fall_edge_enable_r <= hwdata[5:0];
            `PCED_CTRL_OFS: pin_change_master_enable_r <= hwdata[`PCED_CTRL_MEN_BIT];
            default: ;
         endcase
      end
   end

   // Reading a sample a cycle old makes each transition visible for exactly one clock.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pin_prev_r <= 6'h00;
      else
         pin_prev_r <= port_pin;
   end

   assign flag_wr = (phase_r == PCED_WRITE) && (addr_r == `PCED_FLAG_OFS);

   genvar gi;
   generate
      for (gi = 0; gi < `PCED_NPINS; gi++)
      begin : g_pin
         pced_edge_cell u_cell (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin_now(port_pin[gi]),
            .pin_prev(pin_prev_r[gi]),
            .rise_en(rise_edge_enable_r[gi]),
            .fall_en(fall_edge_enable_r[gi]),
            .sw_write(flag_wr),
            .sw_value(hwdata[gi]),
            .flag(flags[gi]),
            .hit(hits[gi])
         );
      end
   endgenerate

   assign pin_change_summary_flag = |flags;
   assign pin_change_irq = pin_change_summary_flag & pin_change_master_enable_r;

   // Wake is a registered one-cycle pulse, one clock after an armed edge, and only while the master enable is set.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wake_req <= 1'b0;
      else
         wake_req <= pin_change_master_enable_r & (|hits);
   end

   always_comb
   begin
      rd_nxt = 32'h00000000;
      case (haddr)
         `PCED_RISE_OFS: rd_nxt = {26'h0, rise_edge_enable_r};
         `PCED_FALL_OFS: rd_nxt = {26'h0, fall_edge_enable_r};
         `PCED_FLAG_OFS: rd_nxt = {26'h0, flags};
         `PCED_CTRL_OFS: rd_nxt = {30'h0, pin_change_summary_flag,
            pin_change_master_enable_r};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_r <= 32'h00000000;
      else if (acc && !hwrite)
         hrdata_r <= rd_nxt;
   end

   assign hrdata = hrdata_r;

   summary_or_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pin_change_summary_flag == (flags != 6'h00))
      else $error("summary flag not OR of flags");
   irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !pin_change_master_enable_r |-> !pin_change_irq)
      else $error("irq with master enable clear");
   detect_masked_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (hits[0] && !pin_change_master_enable_r) |=> flags[0])
      else $error("flag not set while master disabled");
   wake_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (pin_change_master_enable_r && (hits != 6'h00)) |=> wake_req)
      else $error("no wake on enabled edge");
   rise_detect_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rise_edge_enable_r[1] && $rose(port_pin[1])) |=> flags[1])
      else $error("rising edge missed");
   fall_detect_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (fall_edge_enable_r[2] && $fell(port_pin[2])) |=> flags[2])
      else $error("falling edge missed");
   hi_bits_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite) |=> hrdata[31:6] == 26'h0)
      else $error("unimplemented bits read nonzero");
   clear_works_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (flag_wr && !hwdata[3] && !hits[3]) |=> !flags[3])
      else $error("write of zero did not clear");

   irq_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pin_change_irq));
   race_c: cover property (@(posedge hclk) disable iff (!hresetn) flag_wr && (hits != 6'h00));
   wake_c: cover property (@(posedge hclk) disable iff (!hresetn) wake_req);
   masked_flag_c: cover property (@(posedge hclk) disable iff (!hresetn)
      pin_change_summary_flag && !pin_change_master_enable_r);
endmodule

// ===== tb/pced_pin_model.sv
// Model of the external pins that feed the detector.
`timescale 1ns/100ps
module pced_pin_model
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Requested and driven levels.
   input wire logic [5:0] level,
   output logic [5:0] port_pin
);
   // Levels move only on a clock edge, because the design expects pins already in its domain.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         port_pin <= 6'h00;
      else
         port_pin <= level;
   end
endmodule

// ===== tb/pced_top_test.sv
// Testbench for the pin change edge detector: bus tasks and pin scenarios.
`timescale 1ns/100ps
`include "pced_defines.svh"
module pced_top_test;
   import pced_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [5:0] lvl = 6'h00;
   wire logic [31:0] hrdata;
   wire logic hreadyout;
   wire logic hresp;
   wire logic irq;
   wire logic sum;
   wire logic wake;
   wire logic [5:0] port_pin;
   int err_total = 0;
   int total_checks = 0;
   int wakes = 0;
   pced_pin_model pins (.hclk(hclk), .hresetn(hresetn), .level(lvl), .port_pin(port_pin));
   pced_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .port_pin(port_pin), .pin_change_irq(irq),
      .pin_change_summary_flag(sum), .wake_req(wake));
   initial
   begin
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk)
      if (wake === 1'b1)
         wakes <= wakes + 1;
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // The pin request rides on the address phase, so a new edge lands with the write.
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [5:0] p, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      lvl <= p;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      r = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [5:0] p);
      logic [31:0] r;
      xfer(a, 1'b1, d, p, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0, lvl, r);
      chk(r, exp);
   endtask
   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`PCED_RISE_OFS, 32'h0);
      rd(`PCED_FALL_OFS, 32'h0);
      rd(`PCED_FLAG_OFS, 32'h0);
      rd(`PCED_CTRL_OFS, 32'h0);
      chk({30'h0, hresp, hreadyout}, 32'h1);
      wr(`PCED_RISE_OFS, 32'hffffffff, 6'h00);
      rd(`PCED_RISE_OFS, 32'h3f);
      wr(`PCED_FALL_OFS, 32'hffffffff, 6'h00);
      rd(`PCED_FALL_OFS, 32'h3f);
      wr(12'h010, 32'h3, 6'h00);
      rd(12'h010, 32'h0);
      wr(`PCED_RISE_OFS, 32'h5, 6'h00);
      wr(`PCED_FALL_OFS, 32'h6, 6'h00);
      wr(`PCED_RISE_OFS, 32'h5, 6'h07);
      rd(`PCED_FLAG_OFS, 32'h5);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, sum}, 32'h1);
      rd(`PCED_CTRL_OFS, 32'h2);
      // Falling edges on pins 1 and 2 meet this clearing write.
      wr(`PCED_FLAG_OFS, 32'h0, 6'h00);
      rd(`PCED_FLAG_OFS, 32'h6);
      wr(`PCED_FLAG_OFS, 32'h0, 6'h00);
      rd(`PCED_FLAG_OFS, 32'h0);
      chk({31'h0, sum}, 32'h0);
      wr(`PCED_FLAG_OFS, 32'hff, 6'h00);
      rd(`PCED_FLAG_OFS, 32'h3f);
      wr(`PCED_FLAG_OFS, 32'h0, 6'h00);
      chk(wakes, 32'h0);
      wr(`PCED_CTRL_OFS, 32'h1, 6'h00);
      wr(`PCED_RISE_OFS, 32'h5, 6'h01);
      rd(`PCED_FLAG_OFS, 32'h1);
      chk({31'h0, irq}, 32'h1);
      chk(wakes, 32'h1);
      chk({30'h0, hresp, hreadyout}, 32'h1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`PCED_RISE_OFS, 32'h0);
      rd(`PCED_FLAG_OFS, 32'h0);
      rd(`PCED_CTRL_OFS, 32'h0);
      test_done;
   end
   initial
   begin
      #20000;
      err_total++;
      test_done;
   end
endmodule
